/* common/usm_pkg.sv */
// Package with register map, field positions and carrier types of the multiprocessor serial unit
package usm_pkg;

   // ****************************************
   // Register indices (byte address = index * 4)
   // ****************************************
   localparam logic [3:0] IDX_RECEIVE_DATA_LOW = 4'h0;
   localparam logic [3:0] IDX_RECEIVE_DATA_HIGH_FLAGS = 4'h1;
   localparam logic [3:0] IDX_TRANSMIT_DATA_LOW = 4'h2;
   localparam logic [3:0] IDX_TRANSMIT_DATA_HIGH = 4'h3;
   localparam logic [3:0] IDX_STATUS_FLAGS = 4'h4;
   localparam logic [3:0] IDX_CONTROL_IRQ_ENABLES = 4'h5;
   localparam logic [3:0] IDX_CONTROL_RX_TX_MODES = 4'h6;
   localparam logic [3:0] IDX_CONTROL_FRAME_FORMAT = 4'h7;
   localparam logic [3:0] IDX_BAUD_DIVIDER = 4'h8;
   localparam logic [3:0] IDX_CONTROL_AUTOBAUD_WINDOW = 4'ha;
   localparam logic [3:0] IDX_DEBUG_CONTROL = 4'hb;
   localparam logic [3:0] IDX_EVENT_CONTROL = 4'hc;
   localparam logic [3:0] IDX_TX_PULSE_LENGTH = 4'hd;
   localparam logic [3:0] IDX_RX_PULSE_LENGTH = 4'he;
   localparam int ADR_IDX_LSB = 2;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CA_RX_COMPLETE_IRQ_ENABLE = 7;
   localparam int CA_TX_DONE_IRQ_ENABLE = 6;
   localparam int CA_TX_BUFFER_EMPTY_IRQ_ENABLE = 5;
   localparam int CA_RX_START_IRQ_ENABLE = 4;
   localparam int CA_AUTOBAUD_ERROR_IRQ_ENABLE = 2;
   localparam int CB_RX_ENABLE = 7;
   localparam int CB_TX_ENABLE = 6;
   localparam int CB_MULTIPROC_MODE_ENABLE = 0;
   localparam int ST_RX_COMPLETE = 7;
   localparam int ST_TX_DONE = 6;
   localparam int ST_RX_START = 4;
   localparam int ST_INCONSISTENT_SYNC = 3;
   localparam int ST_BREAK_DETECT = 1;
   localparam int ST_WAIT_BREAK = 0;
   localparam int EV_INFRARED_EVENT_INPUT_ENABLE = 0;

   // Character size and communication mode codes
   localparam logic [2:0] CHSIZE_9BIT_LOW_FIRST = 3'h6;
   localparam logic [2:0] CHSIZE_9BIT_HIGH_FIRST = 3'h7;
   localparam logic [1:0] CMODE_SYNC_MASTER = 2'h1;
   localparam logic [1:0] CMODE_SPI_MASTER = 2'h3;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [15:0] RST_BAUD = 16'h0000;
   localparam logic [6:0] RST_RX_PULSE = 7'h00;

   // ****************************************
   // Carrier types
   // ****************************************
   typedef struct packed {
      logic [8:0] data;
      logic stop1;
      logic ferr;
      logic perr;
   } usm_rx_frame_t;

   typedef struct packed {
      logic [8:0] data;
      logic ferr;
      logic perr;
      logic ovf;
   } usm_rx_entry_t;

   typedef struct packed {
      logic rx_complete_vector;
      logic tx_buffer_empty_vector;
      logic tx_done_vector;
   } usm_vectors_t;

endpackage

/* verification/usm_peer.sv */
// Far-side model: frame source of the receiver and transmit shifter
`timescale 1ns/100ps
`default_nettype none

module usm_peer (
   input wire logic clock,
   output usm_pkg::usm_rx_frame_t rx_frame,
   output logic rx_frame_valid,
   input wire logic rx_frame_ready,
   input wire logic [8:0] tx_word,
   input wire logic tx_word_valid,
   output logic tx_word_ready,
   output logic tx_shift_done
);
   logic [8:0] last_word = 9'h000;
   int done_cnt = 0;
   int dly = 0;
   int sh = 0;

   initial begin
      rx_frame = '0;
      rx_frame_valid = 1'h0;
      tx_word_ready = 1'h0;
      tx_shift_done = 1'h0;
   end

   // ****************************************
   // Frame source
   // ****************************************
   // Stop1 carries the frame type, so a short-character sender runs two stop bits
   task automatic send(input logic [8:0] d, input logic s);
      @(posedge clock);
      rx_frame <= {d, s, 2'h0};
      rx_frame_valid <= 1'h1;
      do @(posedge clock); while (rx_frame_ready !== 1'h1);
      rx_frame_valid <= 1'h0;
      rx_frame <= ~{d, s, 2'h0};
   endtask

   // ****************************************
   // Slow shifter: takes a word late, reports the frame gone later
   // ****************************************
   always @(posedge clock) begin
      tx_shift_done <= 1'h0;
      if (tx_word_ready) begin
         tx_word_ready <= 1'h0;
         last_word <= tx_word;
         sh <= 4;
      end else if (tx_word_valid === 1'h1) begin
         dly <= dly + 1;
         if (dly == 3) begin
            tx_word_ready <= 1'h1;
            dly <= 0;
         end
      end
      if (sh != 0) sh <= sh - 1;
      if (sh == 1) begin
         tx_shift_done <= 1'h1;
         done_cnt <= done_cnt + 1;
      end
   end
endmodule

`default_nettype wire

/* verification/usm_usart_mp_test.sv */
// Register-level testbench of the multiprocessor serial unit
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end

module usm_usart_mp_test;
   logic clock = 1'h0;
   logic sys_rst = 1'h1;
   logic clk_en = 1'h1;
   logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, rd;
   logic wb_ack_o, rx_frame_valid, rx_frame_ready, tx_word_valid, tx_word_ready, tx_shift_done;
   usm_pkg::usm_rx_frame_t rx_frame;
   logic rx_start_detected = 1'h0, autobaud_sync_error = 1'h0, break_detected = 1'h0;
   logic tx_done_vector_ack = 1'h0, sync_transfer_clock = 1'h0, ir_rx_pin = 1'h1, ir_event_in = 1'h0;
   logic [8:0] tx_word;
   logic sync_transfer_clock_event, ir_rx_source, rx_enable, tx_enable;
   usm_pkg::usm_vectors_t vectors;
   logic [15:0] baud_divider;
   logic [7:0] frame_format;
   logic [7:0] fl [3] = '{8'h10, 8'h08, 8'h02};
   logic [7:0] en [3] = '{8'h10, 8'h04, 8'h00};
   int err_total = 0, total_checks = 0, cycles = 0;

   always #50 clock = ~clock;

   usm_usart_mp usm_usart_mp_inst (.clock, .sys_rst, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_frame, .rx_frame_valid, .rx_frame_ready,
      .rx_start_detected, .autobaud_sync_error, .break_detected, .tx_word, .tx_word_valid, .tx_word_ready,
      .tx_shift_done, .tx_done_vector_ack, .sync_transfer_clock, .sync_transfer_clock_event, .ir_rx_pin,
      .ir_event_in, .ir_rx_source, .vectors, .baud_divider, .frame_format, .rx_enable, .tx_enable);

   usm_peer usm_peer_inst (.clock, .rx_frame, .rx_frame_valid, .rx_frame_ready, .tx_word, .tx_word_valid,
      .tx_word_ready, .tx_shift_done);

   // ****************************************
   // Bus tasks
   // ****************************************
   task automatic wb_xfer(input logic w, input logic [3:0] idx, input logic [31:0] d);
      int n = 0;
      @(posedge clock);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= {2'h0, idx, 2'h0};
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      do begin @(posedge clock); n++; end while (wb_ack_o !== 1'h1);
      `CHK("ack cycles", 2, n)
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      wb_we_i <= 1'h0;
   endtask

   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      wb_xfer(1'h1, idx, {24'h000000, d});
   endtask

   task automatic rdchk(input logic [3:0] idx, input logic [7:0] e);
      wb_xfer(1'h0, idx, 32'h00000000);
      `CHK("register", {24'h000000, e}, rd)
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clock);
   endtask

   task automatic txsend(input logic [7:0] d);
      int k = usm_peer_inst.done_cnt;
      int n = 0;
      wr(4'h3, 8'h00);
      wr(4'h2, d);
      `CHK("buffer empty vector", 1'h0, vectors.tx_buffer_empty_vector)
      do begin @(posedge clock); n++; end while (usm_peer_inst.done_cnt == k && n < 50);
      @(posedge clock);
      `CHK("word sent", {1'h0, d}, usm_peer_inst.last_word)
      rdchk(4'h4, 8'h60);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         summarize();
      end
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      tick(2);
      sys_rst <= 1'h0;
      rdchk(4'h4, 8'h20);
      rdchk(4'h5, 8'h00);
      rdchk(4'h6, 8'h00);
      wr(4'h9, 8'hff);
      rdchk(4'h9, 8'h00);
      wb_xfer(1'h1, 4'h8, 32'h00001234);
      `CHK("baud", 16'h1234, baud_divider)
      wr(4'ha, 8'hc0);
      rdchk(4'ha, 8'hc0);
      wr(4'he, 8'hff);
      rdchk(4'he, 8'h7f);
      // Address filter, short characters
      wr(4'h7, 8'h03);
      wr(4'h6, 8'hc1);
      `CHK("rx enable", 1'h1, rx_enable)
      usm_peer_inst.send(9'h033, 1'h0);
      rdchk(4'h4, 8'h20);
      usm_peer_inst.send(9'h0a5, 1'h1);
      rdchk(4'h4, 8'ha0);
      wr(4'h5, 8'h80);
      `CHK("rx vector", 1'h1, vectors.rx_complete_vector)
      rdchk(4'h1, 8'h80);
      rdchk(4'h0, 8'ha5);
      rdchk(4'h4, 8'h20);
      `CHK("rx vector", 1'h0, vectors.rx_complete_vector)
      // Address filter, nine-bit characters in both byte orders
      wr(4'h7, 8'h06);
      usm_peer_inst.send(9'h042, 1'h1);
      rdchk(4'h4, 8'h20);
      usm_peer_inst.send(9'h142, 1'h0);
      rdchk(4'h1, 8'h81);
      rdchk(4'h0, 8'h42);
      wr(4'h7, 8'h07);
      usm_peer_inst.send(9'h055, 1'h1);
      rdchk(4'h4, 8'h20);
      wr(4'h6, 8'hc0);
      usm_peer_inst.send(9'h017, 1'h0);
      rdchk(4'h0, 8'h17);
      // Two entries fill the buffer, the third waits
      usm_peer_inst.send(9'h001, 1'h0);
      usm_peer_inst.send(9'h002, 1'h0);
      fork
         usm_peer_inst.send(9'h003, 1'h0);
      join_none
      tick(3);
      `CHK("rx ready", 1'h0, rx_frame_ready)
      rdchk(4'h0, 8'h01);
      rdchk(4'h0, 8'h02);
      rdchk(4'h0, 8'h03);
      rdchk(4'h4, 8'h20);
      usm_peer_inst.send(9'h004, 1'h0);
      wr(4'h6, 8'h40);
      rdchk(4'h4, 8'h20);
      wr(4'h6, 8'hc1);
      // Flag sources with and without enables
      for (int i = 0; i < 3; i++) begin
         @(posedge clock);
         {rx_start_detected, autobaud_sync_error, break_detected} <= 3'h4 >> i;
         @(posedge clock);
         {rx_start_detected, autobaud_sync_error, break_detected} <= 3'h0;
         rdchk(4'h4, 8'h20 | fl[i]);
         `CHK("rx vector", 1'h0, vectors.rx_complete_vector)
         wr(4'h5, en[i]);
         `CHK("rx vector", en[i] != 8'h00, vectors.rx_complete_vector)
         wr(4'h4, fl[i]);
         `CHK("rx vector", 1'h0, vectors.rx_complete_vector)
         rdchk(4'h4, 8'h20);
      end
      // Transmit flags and vectors
      wr(4'h5, 8'h20);
      `CHK("buffer empty vector", 1'h1, vectors.tx_buffer_empty_vector)
      txsend(8'h5a);
      wr(4'h5, 8'h60);
      `CHK("done vector", 1'h1, vectors.tx_done_vector)
      @(posedge clock);
      tx_done_vector_ack <= 1'h1;
      @(posedge clock);
      tx_done_vector_ack <= 1'h0;
      rdchk(4'h4, 8'h20);
      `CHK("done vector", 1'h0, vectors.tx_done_vector)
      txsend(8'hc3);
      wr(4'h4, 8'h40);
      rdchk(4'h4, 8'h20);
      // Transfer clock event in both master modes, none when asynchronous
      for (int i = 0; i < 3; i++) begin
         wr(4'h7, i == 0 ? 8'h43 : (i == 1 ? 8'hc3 : 8'h03));
         sync_transfer_clock <= 1'h1;
         tick(2);
         `CHK("clock event", i < 2, sync_transfer_clock_event)
         sync_transfer_clock <= 1'h0;
         tick(2);
         `CHK("clock event", 1'h0, sync_transfer_clock_event)
      end
      // Infrared input source
      wr(4'hc, 8'h01);
      tick(2);
      `CHK("ir source", 1'h0, ir_rx_source)
      wr(4'hc, 8'h00);
      tick(2);
      `CHK("ir source", 1'h1, ir_rx_source)
      // Frozen unit: no handshake offered, no flag taken
      @(posedge clock);
      clk_en <= 1'h0;
      rx_start_detected <= 1'h1;
      tick(2);
      `CHK("rx ready", 1'h0, rx_frame_ready)
      clk_en <= 1'h1;
      rx_start_detected <= 1'h0;
      rdchk(4'h4, 8'h20);
      // Second reset in mid-run restores the defaults
      wr(4'hc, 8'h01);
      sys_rst <= 1'h1;
      tick(2);
      sys_rst <= 1'h0;
      rdchk(4'h4, 8'h20);
      rdchk(4'h5, 8'h00);
      rdchk(4'he, 8'h00);
      rdchk(4'hc, 8'h00);
      `CHK("vectors", 3'h0, vectors)
      `CHK("ir source", 1'h1, ir_rx_source)
      summarize();
   end
endmodule

`default_nettype wire

/* verilog/usm_usart_mp.sv */
// Multiprocessor frame filter, event logic, interrupt flags and Wishbone register file of the serial unit
`timescale 1ns/100ps
`default_nettype none

module usm_usart_mp (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire usm_pkg::usm_rx_frame_t rx_frame,
   input wire logic rx_frame_valid,
   output logic rx_frame_ready,
   input wire logic rx_start_detected,
   input wire logic autobaud_sync_error,
   input wire logic break_detected,
   output logic [8:0] tx_word,
   output logic tx_word_valid,
   input wire logic tx_word_ready,
   input wire logic tx_shift_done,
   input wire logic tx_done_vector_ack,
   input wire logic sync_transfer_clock,
   output logic sync_transfer_clock_event,
   input wire logic ir_rx_pin,
   input wire logic ir_event_in,
   output logic ir_rx_source,
   output usm_pkg::usm_vectors_t vectors,
   output logic [15:0] baud_divider,
   output logic [7:0] frame_format,
   output logic rx_enable,
   output logic tx_enable
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [7:0] control_irq_enables;
      logic [7:0] control_rx_tx_modes;
      logic [7:0] control_frame_format;
      logic [7:0] control_autobaud_window;
      logic [7:0] debug_control;
      logic [7:0] event_control;
      logic [7:0] txpl;
      logic [6:0] rxpl;
      logic [15:0] baud;
      logic tx_done_flag;
      logic rx_start_flag;
      logic inconsistent_sync_flag;
      logic bdf;
      logic wfb;
      logic tx_full;
      logic tx_hi;
      logic [8:0] tx_data;
      usm_pkg::usm_rx_entry_t [1:0] rxq;
      logic [1:0] rx_cnt;
      logic ovf_pend;
      logic ack;
      logic [31:0] dat;
      logic xck_ev;
      logic ir_src;
   } usm_state_t;

   usm_state_t st_ff;
   usm_state_t nxt_st;

   logic bus_req;
   logic wr_req;
   logic rd_req;
   logic [3:0] idx;
   logic adr_ok;
   logic frame_type;
   logic is_nine;
   logic rx_take;
   logic rx_keep;
   logic rx_pop;
   logic rx_complete_flag;
   logic tx_buffer_empty_flag;
   logic [1:0] cnt_mid;
   logic [31:0] rd_val;
   usm_pkg::usm_rx_entry_t head;

   // ****************************************
   // Bus decode
   // ****************************************
   assign bus_req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
   assign idx = wb_adr_i[usm_pkg::ADR_IDX_LSB +: 4];
   assign adr_ok = (wb_adr_i[7:6] == 2'h0) & (wb_adr_i[1:0] == 2'h0);
   assign wr_req = bus_req & wb_we_i & adr_ok & wb_sel_i[0];
   assign rd_req = bus_req & ~wb_we_i & adr_ok;
   assign head = st_ff.rxq[0];
   assign rx_complete_flag = (st_ff.rx_cnt != 2'h0);
   assign tx_buffer_empty_flag = ~st_ff.tx_full;

   // ****************************************
   // Frame type and receive filter
   // ****************************************
   assign is_nine = (st_ff.control_frame_format[2:0] == usm_pkg::CHSIZE_9BIT_LOW_FIRST) |
                    (st_ff.control_frame_format[2:0] == usm_pkg::CHSIZE_9BIT_HIGH_FIRST);
   assign frame_type = is_nine ? rx_frame.data[8] : rx_frame.stop1;
   // A frame is only taken on an enabled edge, so a frozen unit never loses one
   assign rx_frame_ready = clk_en & ((st_ff.rx_cnt != 2'h2) | ~st_ff.control_rx_tx_modes[usm_pkg::CB_RX_ENABLE]);
   assign rx_take = rx_frame_valid & rx_frame_ready & st_ff.control_rx_tx_modes[usm_pkg::CB_RX_ENABLE];
   // Data frames are dropped while the mode bit is set; address frames pass
   assign rx_keep = rx_take & (~st_ff.control_rx_tx_modes[usm_pkg::CB_MULTIPROC_MODE_ENABLE] | frame_type);
   assign rx_pop = rd_req & wb_sel_i[0] & (idx == usm_pkg::IDX_RECEIVE_DATA_LOW) & rx_complete_flag;
   assign cnt_mid = rx_pop ? st_ff.rx_cnt - 2'h1 : st_ff.rx_cnt;

   // ****************************************
   // Read mux
   // ****************************************
   always_comb begin
      rd_val = 32'h0000_0000;
      case (idx)
         usm_pkg::IDX_RECEIVE_DATA_LOW: rd_val[7:0] = head.data[7:0];
         usm_pkg::IDX_RECEIVE_DATA_HIGH_FLAGS: rd_val[7:0] = {rx_complete_flag, head.ovf, 3'h0, head.ferr, head.perr,
                                                              head.data[8]};
         usm_pkg::IDX_TRANSMIT_DATA_LOW: rd_val[7:0] = st_ff.tx_data[7:0];
         usm_pkg::IDX_TRANSMIT_DATA_HIGH: rd_val[7:0] = {7'h00, st_ff.tx_hi};
         usm_pkg::IDX_STATUS_FLAGS: rd_val[7:0] = {rx_complete_flag, st_ff.tx_done_flag, tx_buffer_empty_flag, st_ff.rx_start_flag, st_ff.inconsistent_sync_flag, 1'b0,
                                                   st_ff.bdf, st_ff.wfb};
         usm_pkg::IDX_CONTROL_IRQ_ENABLES: rd_val[7:0] = st_ff.control_irq_enables;
         usm_pkg::IDX_CONTROL_RX_TX_MODES: rd_val[7:0] = st_ff.control_rx_tx_modes;
         usm_pkg::IDX_CONTROL_FRAME_FORMAT: rd_val[7:0] = st_ff.control_frame_format;
         usm_pkg::IDX_BAUD_DIVIDER: rd_val[15:0] = st_ff.baud;
         usm_pkg::IDX_CONTROL_AUTOBAUD_WINDOW: rd_val[7:0] = st_ff.control_autobaud_window;
         usm_pkg::IDX_DEBUG_CONTROL: rd_val[7:0] = st_ff.debug_control;
         usm_pkg::IDX_EVENT_CONTROL: rd_val[7:0] = st_ff.event_control;
         usm_pkg::IDX_TX_PULSE_LENGTH: rd_val[7:0] = st_ff.txpl;
         usm_pkg::IDX_RX_PULSE_LENGTH: rd_val[7:0] = {1'b0, st_ff.rxpl};
         default: rd_val = 32'h0000_0000;
      endcase
      if (!adr_ok) begin
         rd_val = 32'h0000_0000;
      end
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ack = wb_cyc_i & wb_stb_i & ~st_ff.ack;
      if (bus_req) begin
         nxt_st.dat = wb_we_i ? 32'h0000_0000 : rd_val;
      end

      // Register writes
      if (wr_req) begin
         case (idx)
            usm_pkg::IDX_TRANSMIT_DATA_LOW: begin
               if (!st_ff.tx_full) begin
                  nxt_st.tx_data = {st_ff.tx_hi, wb_dat_i[7:0]};
                  nxt_st.tx_full = 1'b1;
               end
            end
            usm_pkg::IDX_TRANSMIT_DATA_HIGH: nxt_st.tx_hi = wb_dat_i[0];
            usm_pkg::IDX_STATUS_FLAGS: begin
               if (wb_dat_i[usm_pkg::ST_TX_DONE]) begin
                  nxt_st.tx_done_flag = 1'b0;
               end
               if (wb_dat_i[usm_pkg::ST_RX_START]) begin
                  nxt_st.rx_start_flag = 1'b0;
               end
               if (wb_dat_i[usm_pkg::ST_INCONSISTENT_SYNC]) begin
                  nxt_st.inconsistent_sync_flag = 1'b0;
               end
               if (wb_dat_i[usm_pkg::ST_BREAK_DETECT]) begin
                  nxt_st.bdf = 1'b0;
               end
               nxt_st.wfb = wb_dat_i[usm_pkg::ST_WAIT_BREAK];
            end
            usm_pkg::IDX_CONTROL_IRQ_ENABLES: nxt_st.control_irq_enables = wb_dat_i[7:0];
            usm_pkg::IDX_CONTROL_RX_TX_MODES: nxt_st.control_rx_tx_modes = wb_dat_i[7:0];
            usm_pkg::IDX_CONTROL_FRAME_FORMAT: nxt_st.control_frame_format = wb_dat_i[7:0];
            usm_pkg::IDX_BAUD_DIVIDER: begin
               nxt_st.baud[7:0] = wb_dat_i[7:0];
               if (wb_sel_i[1]) begin
                  nxt_st.baud[15:8] = wb_dat_i[15:8];
               end
            end
            usm_pkg::IDX_CONTROL_AUTOBAUD_WINDOW: nxt_st.control_autobaud_window = wb_dat_i[7:0];
            usm_pkg::IDX_DEBUG_CONTROL: nxt_st.debug_control = wb_dat_i[7:0];
            usm_pkg::IDX_EVENT_CONTROL: nxt_st.event_control = wb_dat_i[7:0];
            usm_pkg::IDX_TX_PULSE_LENGTH: nxt_st.txpl = wb_dat_i[7:0];
            usm_pkg::IDX_RX_PULSE_LENGTH: nxt_st.rxpl = wb_dat_i[6:0];
            default: nxt_st.control_irq_enables = nxt_st.control_irq_enables;
         endcase
      end

      // Vector execution clears the done flag
      if (tx_done_vector_ack) begin
         nxt_st.tx_done_flag = 1'b0;
      end

      // Transmit buffer hand-off to the shifter
      if (st_ff.tx_full & st_ff.control_rx_tx_modes[usm_pkg::CB_TX_ENABLE] & tx_word_ready) begin
         nxt_st.tx_full = 1'b0;
      end

      // Hardware sets win over software clears
      if (tx_shift_done & ~st_ff.tx_full) begin
         nxt_st.tx_done_flag = 1'b1;
      end
      if (rx_start_detected) begin
         nxt_st.rx_start_flag = 1'b1;
      end
      if (autobaud_sync_error) begin
         nxt_st.inconsistent_sync_flag = 1'b1;
      end
      if (break_detected) begin
         nxt_st.bdf = 1'b1;
      end

      // Receive buffer: pop on low byte read, then push an accepted frame
      if (rx_pop) begin
         nxt_st.rxq[0] = st_ff.rxq[1];
         nxt_st.ovf_pend = nxt_st.ovf_pend;
      end
      nxt_st.rx_cnt = cnt_mid;
      if (rx_start_detected & (st_ff.rx_cnt == 2'h2) & ~rx_pop) begin
         nxt_st.ovf_pend = 1'b1;
      end
      if (rx_keep) begin
         nxt_st.rxq[cnt_mid[0]] = '{data: rx_frame.data, ferr: rx_frame.ferr, perr: rx_frame.perr,
                                    ovf: st_ff.ovf_pend};
         nxt_st.rx_cnt = cnt_mid + 2'h1;
         nxt_st.ovf_pend = 1'b0;
      end
      if (!st_ff.control_rx_tx_modes[usm_pkg::CB_RX_ENABLE]) begin
         nxt_st.rx_cnt = 2'h0;
         nxt_st.ovf_pend = 1'b0;
      end

      // Transfer clock event and infrared source select
      nxt_st.xck_ev = sync_transfer_clock & ((st_ff.control_frame_format[7:6] == usm_pkg::CMODE_SYNC_MASTER) |
                                             (st_ff.control_frame_format[7:6] == usm_pkg::CMODE_SPI_MASTER));
      nxt_st.ir_src = st_ff.event_control[usm_pkg::EV_INFRARED_EVENT_INPUT_ENABLE] ? ir_event_in : ir_rx_pin;
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_ff <= '0;
         st_ff.control_irq_enables <= usm_pkg::RST_CTRL;
         st_ff.control_rx_tx_modes <= usm_pkg::RST_CTRL;
         st_ff.control_frame_format <= usm_pkg::RST_CTRL;
         st_ff.baud <= usm_pkg::RST_BAUD;
         st_ff.rxpl <= usm_pkg::RST_RX_PULSE;
         st_ff.ir_src <= 1'b1;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign wb_ack_o = st_ff.ack;
   assign wb_dat_o = st_ff.dat;
   assign tx_word = st_ff.tx_data;
   // Held back while frozen, so the shifter cannot take the same word twice
   assign tx_word_valid = clk_en & st_ff.tx_full & st_ff.control_rx_tx_modes[usm_pkg::CB_TX_ENABLE];
   assign sync_transfer_clock_event = st_ff.xck_ev;
   assign ir_rx_source = st_ff.ir_src;
   assign baud_divider = st_ff.baud;
   assign frame_format = st_ff.control_frame_format;
   assign rx_enable = st_ff.control_rx_tx_modes[usm_pkg::CB_RX_ENABLE];
   assign tx_enable = st_ff.control_rx_tx_modes[usm_pkg::CB_TX_ENABLE];
   assign vectors.rx_complete_vector = (st_ff.control_irq_enables[usm_pkg::CA_RX_COMPLETE_IRQ_ENABLE] & rx_complete_flag) |
                                       (st_ff.control_irq_enables[usm_pkg::CA_RX_START_IRQ_ENABLE] & st_ff.rx_start_flag) |
                                       (st_ff.control_irq_enables[usm_pkg::CA_AUTOBAUD_ERROR_IRQ_ENABLE] & st_ff.inconsistent_sync_flag);
   assign vectors.tx_buffer_empty_vector = st_ff.control_irq_enables[usm_pkg::CA_TX_BUFFER_EMPTY_IRQ_ENABLE] & tx_buffer_empty_flag;
   assign vectors.tx_done_vector = st_ff.control_irq_enables[usm_pkg::CA_TX_DONE_IRQ_ENABLE] & st_ff.tx_done_flag;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   data_frame_drop_a: assert property (
      clk_en & rx_take & st_ff.control_rx_tx_modes[usm_pkg::CB_MULTIPROC_MODE_ENABLE] & ~frame_type & (st_ff.rx_cnt == 2'h0)
      |=> (st_ff.rx_cnt == 2'h0))
      else $error("data frame kept in multiprocessor mode");

   addr_frame_kept_a: assert property (
      clk_en & rx_take & frame_type & (st_ff.rx_cnt == 2'h0) |=> rx_complete_flag && (head.data == $past(rx_frame.data)))
      else $error("address frame not buffered");

   nine_bit_type_a: assert property (
      is_nine & rx_take & st_ff.control_rx_tx_modes[usm_pkg::CB_MULTIPROC_MODE_ENABLE] |-> (rx_keep == rx_frame.data[8]))
      else $error("ninth bit not used as frame type");

   stop_bit_type_a: assert property (
      ~is_nine & rx_take & st_ff.control_rx_tx_modes[usm_pkg::CB_MULTIPROC_MODE_ENABLE] |-> (rx_keep == rx_frame.stop1))
      else $error("stop bit not used as frame type");

   rx_vector_a: assert property (
      st_ff.control_irq_enables[usm_pkg::CA_RX_COMPLETE_IRQ_ENABLE] & rx_complete_flag |-> vectors.rx_complete_vector)
      else $error("receive vector missing");

   dre_vector_a: assert property (
      clk_en & wr_req & (idx == usm_pkg::IDX_TRANSMIT_DATA_LOW) & tx_buffer_empty_flag & ~tx_word_ready
      |=> ~vectors.tx_buffer_empty_vector)
      else $error("empty vector stays after buffer load");

   tx_done_set_a: assert property (
      clk_en & tx_shift_done & ~st_ff.tx_full |=> st_ff.tx_done_flag)
      else $error("transmit done flag not set");

   tx_done_clr_a: assert property (
      clk_en & tx_done_vector_ack & ~tx_shift_done |=> ~st_ff.tx_done_flag ##1 1'b1)
      else $error("transmit done flag not cleared");

   rx_flush_a: assert property (
      clk_en & ~st_ff.control_rx_tx_modes[usm_pkg::CB_RX_ENABLE] |=> ~rx_complete_flag)
      else $error("receive buffer not flushed");

   ir_select_a: assert property (
      clk_en & st_ff.event_control[usm_pkg::EV_INFRARED_EVENT_INPUT_ENABLE] |=> (ir_rx_source == $past(ir_event_in)))
      else $error("infrared event input not selected");

   wb_ack_a: assert property (
      clk_en & bus_req |=> wb_ack_o ##1 (~wb_ack_o | ~$past(clk_en)))
      else $error("bus answer not one cycle");

   freeze_hold_a: assert property (
      ~clk_en |=> (st_ff == $past(st_ff)))
      else $error("state changed with clock enable low");

   dre_valid_a: assert property (
      vectors.tx_buffer_empty_vector |-> ~tx_word_valid)
      else $error("empty vector while a word waits");

   cover_addr_c: cover property (rx_keep & st_ff.control_rx_tx_modes[usm_pkg::CB_MULTIPROC_MODE_ENABLE]);
   cover_full_c: cover property (st_ff.rx_cnt == 2'h2);
   cover_txdone_c: cover property (vectors.tx_done_vector);
   cover_event_c: cover property (sync_transfer_clock_event);
   cover_irsrc_c: cover property (st_ff.event_control[usm_pkg::EV_INFRARED_EVENT_INPUT_ENABLE] & ~ir_rx_source);

endmodule
`default_nettype wire
